// File: src/cbs_core_buffer_sequencer.sv
/*
 * Core buffer sequencer: address counters, write burst generation, access timing,
 * frame tag output and section occupancy for a 15x44 bit-serial core store.
 * Assumes all pulse inputs are one clock wide, synchronous, and that the
 * controlling logic never presents a write burst and a read pulse together.
 */
// Function
// - Only 15 columns by 44 rows, 660 locations, are ever addressed.
// - Switches turn on before drivers; drivers turn off before switches.
// - Output amplifier stays off until a strobe mid read pulse.
// - Separate read and write row/column counters, each stepped by own advance.
// - Row counter wraps after 44 advances and emits one column advance.
// - Column low section cycles five states then advances upper section.
// - Upper section counts to 2; third advance clears both sections.
// - Each write pulse yields a burst of 2 or 7 write commands.
// - A write-row advance follows each write command of a burst.
// - Write command samples address and data, then drives selected lines.
// - Each shift-data pulse reads one location and generates the strobe.
// - Frame counter counts 1 to 15, stepped by read column advance.
// - Tag counter counts 0 to 3, stepped by each tag shift pulse.
// - Counters decode to a tag bit sent through the shared output.
// - One empty flag per section, high while section is empty.
// - Write clears a section's flag; reading it out sets it again.
// - Write counter parked at start of unread section raises overflow and blocks new bursts.
// - Reads about to scan an empty section are held off.
// - Column select picks one of 3 drivers and one of 5 switches.
// - Row select picks one of 8 drivers, one of 6 switches; linked rows.
// - Reading is destructive; read bits return to zero.
`timescale 1ns/1ps
module cbs_core_buffer_sequencer (
    input  wire logic              clk,
    input  wire logic              rstn,
    input  wire logic              write_pulse,
    input  wire logic              status_bit_pair,
    input  wire logic              write_data,
    input  wire logic              shift_data_pulse,
    input  wire logic              frame_tag_shift_pulse,
    input  wire logic              sense_one,
    output cbs_pkg::cbs_sel_t      sel,
    output logic                   switch_en,
    output logic                   driver_en,
    output logic                   write_mode,
    output logic                   write_bit,
    output logic                   strobe,
    output logic                   data_out,
    output logic                   frame_tag_bit,
    output logic                   store_overflow_flag,
    output logic                   section_one_empty,
    output logic                   section_two_empty,
    output logic                   section_three_empty,
    output cbs_pkg::cbs_addr_t     wr_addr,
    output cbs_pkg::cbs_addr_t     rd_addr
);
    import cbs_pkg::*;

    typedef enum logic [4:0] {
        ST_IDLE   = 5'b00001,
        ST_SWITCH = 5'b00010,
        ST_DRIVE  = 5'b00100,
        ST_RELEASE= 5'b01000,
        ST_ADV    = 5'b10000
    } cbs_state_t;

    cbs_state_t  state;
    cbs_state_t  next_state;
    logic [7:0]  timer;
    logic [2:0]  burst_left;
    logic        is_write;
    logic        wr_adv;
    logic        rd_adv;
    logic        wr_col_adv;
    logic        rd_col_adv;
    logic [2:0]  empty;
    logic [3:0]  frame_cnt;
    logic [1:0]  tag_cnt;
    logic        sensed;
    cbs_addr_t   wr_addr_i;
    cbs_addr_t   rd_addr_i;

    cbs_addr_ctr u_wr_ctr (
        .clk     (clk),
        .rstn    (rstn),
        .adv     (wr_adv),
        .addr    (wr_addr_i),
        .col_adv (wr_col_adv)
    );
    cbs_addr_ctr u_rd_ctr (
        .clk     (clk),
        .rstn    (rstn),
        .adv     (rd_adv),
        .addr    (rd_addr_i),
        .col_adv (rd_col_adv)
    );

    // A write counter parked on a section's first location is about to enter it.
    // Checking here, not at the last location, never blocks finishing a section.
    wire        wr_at_start = (wr_addr_i.row == 6'h00) && (wr_addr_i.col_lo == 3'h0);
    wire        full_now   = wr_at_start && !empty[wr_addr_i.col_hi];
    wire        rd_blocked = empty[rd_addr_i.col_hi];
    wire        take_write = write_pulse && (state == ST_IDLE)
                          && !store_overflow_flag && !full_now;
    wire        take_read  = shift_data_pulse && (state == ST_IDLE)
                          && !take_write && !rd_blocked;
    wire        timer_done = (timer == 8'h00);
    wire        cur_write  = (state == ST_IDLE) ? take_write : is_write;
    cbs_addr_t  cur_addr;
    assign cur_addr = cur_write ? wr_addr_i : rd_addr_i;
    // Step in the last release cycle, so the next command of a burst latches
    // its selection from the address that it really drives.
    assign wr_adv = (state == ST_RELEASE) && timer_done && is_write;
    assign rd_adv = (state == ST_RELEASE) && timer_done && !is_write;
    // Rows eight apart share a driver line: driver is row mod 8, switch is row / 8, for read and write alike.
    wire [2:0]  row_drv_i  = 3'(cur_addr.row % 6'h08);
    wire [2:0]  row_sw_i   = 3'(cur_addr.row / 6'h08);
    wire        tag_decode = frame_cnt[tag_cnt];
    wire        rd_hi_chg  = rd_col_adv && (rd_addr_i.row == 6'h00)
                          && (rd_addr_i.col_lo == 3'h0);
    wire [1:0]  rd_prev_hi = (rd_addr_i.col_hi == 2'h0) ? 2'(COL_HIGH_MOD - 1)
                          : rd_addr_i.col_hi - 2'h1;

    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE:    if (take_write || take_read) next_state = ST_SWITCH;
            ST_SWITCH:  if (timer_done) next_state = ST_DRIVE;
            ST_DRIVE:   if (timer_done) next_state = ST_RELEASE;
            ST_RELEASE: if (timer_done) next_state = ST_ADV;
            ST_ADV:     next_state = (is_write && burst_left != 3'h0) ? ST_SWITCH : ST_IDLE;
            default:    next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state <= ST_IDLE;
            timer <= 8'h00;
        end else begin
            state <= next_state;
            if (next_state != state || state == ST_ADV) begin
                timer <= (next_state == ST_DRIVE) ? 8'(DRIVE_CYC - 1) : 8'(SETTLE_CYC - 1);
            end else if (!timer_done) begin
                timer <= timer - 8'h01;
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            is_write   <= 1'b0;
            burst_left <= 3'h0;
            write_bit  <= 1'b0;
        end else begin
            if (take_write) begin
                is_write   <= 1'b1;
                burst_left <= status_bit_pair ? 3'(BURST_PAIR - 1)
                                              : 3'(BURST_WORD - 1);
            end else if (take_read) begin
                is_write <= 1'b0;
            end else if (state == ST_ADV && is_write && burst_left != 3'h0) begin
                burst_left <= burst_left - 3'h1;
            end
            if (next_state == ST_SWITCH && cur_write) begin
                write_bit <= write_data;
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sel        <= '0;
            switch_en  <= 1'b0;
            driver_en  <= 1'b0;
            write_mode <= 1'b0;
            strobe     <= 1'b0;
            sensed     <= 1'b0;
            data_out   <= 1'b0;
        end else begin
            if (next_state == ST_SWITCH && state != ST_SWITCH) begin
                sel.col_drv <= 3'h1 << cur_addr.col_hi;
                sel.col_sw  <= 5'h01 << cur_addr.col_lo;
                sel.row_drv <= 8'h01 << row_drv_i;
                sel.row_sw  <= 6'h01 << row_sw_i;
                write_mode  <= cur_write;
            end
            switch_en <= (next_state == ST_SWITCH) || (next_state == ST_DRIVE)
                      || (next_state == ST_RELEASE);
            driver_en <= (next_state == ST_DRIVE);
            strobe    <= (next_state == ST_DRIVE) && !is_write
                      && (timer == 8'(STROBE_CYC));
            sensed    <= strobe && sense_one;
            data_out  <= sensed || (frame_tag_shift_pulse && tag_decode);
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            frame_cnt     <= FRAME_RESET;
            tag_cnt       <= 2'h0;
            frame_tag_bit <= 1'b0;
        end else begin
            if (rd_col_adv) begin
                frame_cnt <= (frame_cnt == 4'(FRAME_LAST)) ? 4'(FRAME_FIRST)
                                                           : frame_cnt + 4'h1;
            end
            if (frame_tag_shift_pulse) begin
                tag_cnt <= (tag_cnt == 2'(TAG_LAST)) ? 2'h0 : tag_cnt + 2'h1;
            end
            frame_tag_bit <= tag_decode;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            empty               <= SECT_EMPTY_RV;
            store_overflow_flag <= 1'b0;
        end else begin
            // A section is claimed when written into and released after readout.
            for (int i = 0; i < SECTIONS; i++) begin
                if (wr_adv && wr_addr_i.row == 6'h00 && wr_addr_i.col_lo == 3'h0
                    && wr_addr_i.col_hi == 2'(i)) begin
                    empty[i] <= 1'b0;
                end else if (rd_hi_chg && rd_prev_hi == 2'(i)) begin
                    empty[i] <= 1'b1;
                end
            end
            store_overflow_flag <= full_now;
        end
    end

    assign section_one_empty   = empty[0];
    assign section_two_empty   = empty[1];
    assign section_three_empty = empty[2];
    assign wr_addr             = wr_addr_i;
    assign rd_addr             = rd_addr_i;

    // One counter serves both ends of a drive window: switch-on cycles with drivers off.
    logic [7:0]  gap_cnt;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            gap_cnt <= 8'h00;
        end else if (!switch_en || driver_en) begin
            gap_cnt <= 8'h00;
        end else if (gap_cnt != 8'hff) begin
            gap_cnt <= gap_cnt + 8'h01;
        end
    end

    property p_drv_inside_sw;
        @(posedge clk) disable iff (!rstn) driver_en |-> switch_en;
    endproperty
    a_drv_inside_sw: assert property (p_drv_inside_sw) else $error("drive without switch");
    property p_sw_lead;
        @(posedge clk) disable iff (!rstn) $rose(driver_en) |-> gap_cnt >= 8'(SETTLE_CYC);
    endproperty
    a_sw_lead: assert property (p_sw_lead) else $error("switch lead too short");
    property p_sw_lag;
        @(posedge clk) disable iff (!rstn) $fell(switch_en) |-> gap_cnt >= 8'(SETTLE_CYC);
    endproperty
    a_sw_lag: assert property (p_sw_lag) else $error("switch lag too short");
    property p_strobe_read;
        @(posedge clk) disable iff (!rstn) strobe |-> driver_en && !write_mode;
    endproperty
    a_strobe_read: assert property (p_strobe_read) else $error("strobe outside read");
    property p_row_range;
        @(posedge clk) disable iff (!rstn) wr_addr_i.row < 6'd44 && rd_addr_i.row < 6'd44;
    endproperty
    a_row_range: assert property (p_row_range) else $error("row out of range");
    property p_col_range;
        @(posedge clk) disable iff (!rstn) wr_addr_i.col_lo < 3'd5 && wr_addr_i.col_hi < 2'd3;
    endproperty
    a_col_range: assert property (p_col_range) else $error("column out of range");
    property p_frame_range;
        @(posedge clk) disable iff (!rstn) frame_cnt >= 4'd1 && frame_cnt <= 4'd15;
    endproperty
    a_frame_range: assert property (p_frame_range) else $error("frame out of range");
    property p_full_ignore;
        @(posedge clk) disable iff (!rstn) store_overflow_flag && state == ST_IDLE
            |=> !(state == ST_SWITCH && is_write);
    endproperty
    a_full_ignore: assert property (p_full_ignore) else $error("write taken when full");
    property p_wr_adv_after;
        @(posedge clk) disable iff (!rstn) state == ST_ADV && is_write
            |-> wr_addr_i != $past(wr_addr_i);
    endproperty
    a_wr_adv_after: assert property (p_wr_adv_after) else $error("missing write advance");
    property p_col_carry;
        @(posedge clk) disable iff (!rstn) wr_col_adv
            |-> wr_addr_i.row == 6'h00 && $past(wr_addr_i.row) == 6'(ROW_COUNT - 1);
    endproperty
    a_col_carry: assert property (p_col_carry) else $error("column advance off row wrap");
    property p_rd_blocked;
        @(posedge clk) disable iff (!rstn) shift_data_pulse && !write_pulse && rd_blocked
            && state == ST_IDLE |=> state == ST_IDLE;
    endproperty
    a_rd_blocked: assert property (p_rd_blocked) else $error("read of empty section");
    property p_bit_hold;
        @(posedge clk) disable iff (!rstn) driver_en && write_mode |-> $stable(write_bit);
    endproperty
    a_bit_hold: assert property (p_bit_hold) else $error("write bit moved in drive");
    property p_sel_hold;
        @(posedge clk) disable iff (!rstn) switch_en && $past(switch_en) |-> $stable(sel);
    endproperty
    a_sel_hold: assert property (p_sel_hold) else $error("selection moved in access");
    c_write: cover property (@(posedge clk) disable iff (!rstn) wr_adv);
    c_pair:  cover property (@(posedge clk) disable iff (!rstn) take_write && status_bit_pair);
    c_read:  cover property (@(posedge clk) disable iff (!rstn) strobe);
    c_full:  cover property (@(posedge clk) disable iff (!rstn) store_overflow_flag);
endmodule : cbs_core_buffer_sequencer

// File: src/cbs_pkg.sv
/*
 * Package for the core buffer sequencer: address limits, counter moduli, access
 * phase lengths, burst lengths and the carrier structs for driver selection.
 * Assumes a single 20 MHz clock domain.
 */
package cbs_pkg;
    localparam int unsigned CLK_HZ       = 20_000_000;
    localparam int unsigned ROW_COUNT    = 44;
    localparam int unsigned COL_LOW_MOD  = 5;
    localparam int unsigned COL_HIGH_MOD = 3;
    localparam int unsigned SECTIONS     = 3;
    localparam int unsigned LOCATIONS    = 660;
    localparam int unsigned BURST_PAIR   = 2;
    localparam int unsigned BURST_WORD   = 7;
    localparam int unsigned FRAME_FIRST  = 1;
    localparam int unsigned FRAME_LAST   = 15;
    localparam int unsigned TAG_LAST     = 3;

    // Settle times in ns, turned into cycle counts (least time, rounded up).
    localparam int unsigned SETTLE_NS     = 500;
    localparam int unsigned DRIVE_NS      = 2000;
    localparam int unsigned SETTLE_CYC    = (SETTLE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int unsigned DRIVE_CYC     = (DRIVE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int unsigned STROBE_CYC    = DRIVE_CYC / 2;
    localparam logic [3:0]  FRAME_RESET   = 4'h1;
    localparam logic [2:0]  SECT_EMPTY_RV = 3'h7;

    typedef struct packed {
        logic [2:0] col_drv;
        logic [4:0] col_sw;
        logic [7:0] row_drv;
        logic [5:0] row_sw;
    } cbs_sel_t;

    typedef struct packed {
        logic [5:0] row;
        logic [2:0] col_lo;
        logic [1:0] col_hi;
    } cbs_addr_t;
endpackage : cbs_pkg

// File: src/cbs_addr_ctr.sv
/*
 * One row/column address counter pair for either the read or the write side.
 * Assumes advance pulses are one clock wide and synchronous to clk.
 */
`timescale 1ns/1ps
module cbs_addr_ctr (
    input  wire logic             clk,
    input  wire logic             rstn,
    input  wire logic             adv,
    output cbs_pkg::cbs_addr_t    addr,
    output logic                  col_adv
);
    import cbs_pkg::*;

    wire row_wrap = (addr.row == 6'(ROW_COUNT - 1));
    wire lo_wrap  = (addr.col_lo == 3'(COL_LOW_MOD - 1));
    wire hi_wrap  = (addr.col_hi == 2'(COL_HIGH_MOD - 1));

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            addr    <= '0;
            col_adv <= 1'b0;
        end else begin
            col_adv <= adv && row_wrap;
            if (adv) begin
                addr.row <= row_wrap ? 6'h00 : addr.row + 6'h01;
                if (row_wrap) begin
                    if (lo_wrap) begin
                        addr.col_lo <= 3'h0;
                        addr.col_hi <= hi_wrap ? 2'h0 : addr.col_hi + 2'h1;
                    end else begin
                        addr.col_lo <= addr.col_lo + 3'h1;
                    end
                end
            end
        end
    end
endmodule : cbs_addr_ctr

// File: verification/cbs_core_plane_model.sv
/*
 * Behavioural core plane and sense amplifier for the core buffer sequencer bench.
 * Assumes wr_addr and rd_addr name the cell that the current access drives.
 */
`timescale 1ns/1ps
module cbs_core_plane_model (
    input  wire logic               clk,
    input  wire logic               rstn,
    input  wire logic               driver_en,
    input  wire logic               write_mode,
    input  wire logic               write_bit,
    input  wire cbs_pkg::cbs_addr_t wr_addr,
    input  wire cbs_pkg::cbs_addr_t rd_addr,
    output logic                    sense_one
);
    import cbs_pkg::*;
    logic        mem [LOCATIONS];
    logic        held;
    logic        drv_q;
    logic        flip;
    cbs_addr_t   cur;
    int unsigned idx;

    assign cur = write_mode ? wr_addr : rd_addr;
    assign idx = cur.row + ROW_COUNT * (cur.col_lo + COL_LOW_MOD * cur.col_hi);
    // Outside a read drive the sense line is noise, so a stale bit never passes as data.
    assign sense_one = (driver_en && !write_mode) ? held : flip;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            drv_q <= 1'b0;
            held <= 1'b0;
            flip <= 1'b0;
            for (int i = 0; i < LOCATIONS; i++) begin
                mem[i] <= 1'b0;
            end
        end else begin
            drv_q <= driver_en;
            flip <= !flip;
            if (driver_en && !drv_q && write_mode) begin
                mem[idx] <= write_bit;
            end
            if (driver_en && !drv_q && !write_mode) begin
                held <= mem[idx];
                mem[idx] <= 1'b0;
            end
        end
    end
endmodule : cbs_core_plane_model

// File: verification/cbs_core_buffer_sequencer_bench.sv
/*
 * Self-checking bench: fills the store by write bursts, reads it all back and
 * checks addresses, data, flags and frame tags. Assumes the core plane model.
 */
`timescale 1ns/1ps
module cbs_core_buffer_sequencer_bench;
    import cbs_pkg::*;
    logic       clk = 1'b0;
    logic       rstn = 1'b0;
    logic [2:0] req = 3'h0;
    logic       status_bit_pair = 1'b0;
    logic       write_data = 1'b0;
    logic       sense_one, switch_en, driver_en, write_mode, write_bit, strobe;
    logic       data_out, frame_tag_bit, store_overflow_flag;
    logic       section_one_empty, section_two_empty, section_three_empty;
    logic [2:0] empties;
    cbs_sel_t   sel;
    cbs_addr_t  wr_addr, rd_addr;
    cbs_addr_t  cur_a;
    logic       col_ok;
    int         n_errors = 0;
    int         cmp_count = 0;
    int         cycles = 0;
    int         n_strobe, n, len;
    logic       got, started;
    logic [3:0] frame = FRAME_RESET;

    assign empties = {section_three_empty, section_two_empty, section_one_empty};
    // The driven cell's column picks its switch by low count and driver by section.
    assign cur_a = write_mode ? wr_addr : rd_addr;
    assign col_ok = sel.col_sw[cur_a.col_lo] && sel.col_drv[cur_a.col_hi];
    always #25 clk = ~clk;

    cbs_core_buffer_sequencer u_cbs_core_buffer_sequencer (
        .clk(clk), .rstn(rstn), .write_pulse(req[0]), .status_bit_pair(status_bit_pair),
        .write_data(write_data), .shift_data_pulse(req[1]),
        .frame_tag_shift_pulse(req[2]), .sense_one(sense_one), .sel(sel),
        .switch_en(switch_en), .driver_en(driver_en), .write_mode(write_mode),
        .write_bit(write_bit), .strobe(strobe), .data_out(data_out),
        .frame_tag_bit(frame_tag_bit), .store_overflow_flag(store_overflow_flag),
        .section_one_empty(section_one_empty), .section_two_empty(section_two_empty),
        .section_three_empty(section_three_empty), .wr_addr(wr_addr), .rd_addr(rd_addr));

    cbs_core_plane_model u_cbs_core_plane_model (
        .clk(clk), .rstn(rstn), .driver_en(driver_en), .write_mode(write_mode),
        .write_bit(write_bit), .wr_addr(wr_addr), .rd_addr(rd_addr), .sense_one(sense_one));

    task automatic report_and_stop();
        if (n_errors == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : report_and_stop

    task automatic check(input logic ok, input string msg);
        cmp_count++;
        if (ok !== 1'b1) begin
            n_errors++;
            $display("FAIL at %0t: %s", $time, msg);
        end
    endtask : check

    function automatic cbs_addr_t exp_addr(input int k);
        cbs_addr_t a;
        a.row = 6'(k % ROW_COUNT);
        a.col_lo = 3'((k / ROW_COUNT) % COL_LOW_MOD);
        a.col_hi = 2'((k / (ROW_COUNT * COL_LOW_MOD)) % COL_HIGH_MOD);
        return a;
    endfunction : exp_addr

    function automatic logic pat(input int k);
        return (k % 3) == 0;
    endfunction : pat

    task automatic pulse(input int b);
        @(posedge clk);
        req[b] <= 1'b1;
        @(posedge clk);
        req[b] <= 1'b0;
    endtask : pulse

    // Waits for one access to start and end, collecting strobes and output pulses.
    task automatic wait_access(input int tail);
        started = 1'b0;
        got = 1'b0;
        n_strobe = 0;
        for (int i = 0; i < 20 && !started; i++) begin
            @(posedge clk);
            #1;
            started = (switch_en === 1'b1);
        end
        for (int i = 0; i < 200 && switch_en === 1'b1; i++) begin
            @(posedge clk);
            #1;
            got |= data_out;
            n_strobe += (strobe === 1'b1);
        end
        repeat (tail) @(posedge clk);
    endtask : wait_access

    task automatic burst(input int blen, input int n0);
        @(posedge clk);
        status_bit_pair <= (blen == BURST_PAIR);
        write_data <= pat(n0);
        req[0] <= 1'b1;
        @(posedge clk);
        req[0] <= 1'b0;
        for (int i = 0; i < blen; i++) begin
            wait_access(0);
            check(started, "write command missing");
            write_data <= pat(n0 + i + 1);
        end
        repeat (4) @(posedge clk);
    endtask : burst

    task automatic tag_round();
        for (int t = 0; t < 4; t++) begin
            check(frame_tag_bit === frame[t], "frame tag level");
            pulse(2);
            #1;
            got = data_out;
            repeat (3) begin
                @(posedge clk);
                #1;
                got |= data_out;
            end
            check(got === frame[t], "frame tag bit");
        end
    endtask : tag_round

    always @(negedge clk) begin
        if (rstn) begin
            if (driver_en === 1'b1) check(switch_en === 1'b1, "drive without switch");
            if (switch_en === 1'b1) check($onehot(sel.col_drv) && $onehot(sel.col_sw), "col");
            if (switch_en === 1'b1) check($onehot(sel.row_drv) && $onehot(sel.row_sw), "row");
            if (driver_en === 1'b1) check(col_ok === 1'b1, "column select");
            if (strobe === 1'b1) check(driver_en && !write_mode, "strobe outside read");
            cycles++;
            if (cycles == 99000) begin
                check(1'b0, "timeout");
                report_and_stop();
            end
        end
    end

    initial begin
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        #1;
        check(empties === SECT_EMPTY_RV && store_overflow_flag === 1'b0, "reset");
        tag_round();
        pulse(1);
        wait_access(0);
        check(!started && rd_addr === exp_addr(0), "read of empty section taken");
        // Reads and writes are never requested together: each waits for the last access.
        for (n = 0; n < LOCATIONS; n += len) begin
            len = (LOCATIONS - n >= BURST_WORD) ? BURST_WORD : BURST_PAIR;
            burst(len, n);
            check(wr_addr === exp_addr(n + len), "write address");
            if (n + len < 440) check(store_overflow_flag === 1'b0, "early overflow");
        end
        check(store_overflow_flag === 1'b1 && empties === 3'h0, "store not full");
        pulse(0);
        wait_access(0);
        check(!started && wr_addr === exp_addr(0), "write taken while full");
        for (int k = 0; k < LOCATIONS; k++) begin
            pulse(1);
            wait_access(4);
            check(started && n_strobe == 1, "read access");
            check(got === pat(k), "read data");
            if (k < LOCATIONS - 1) check(rd_addr === exp_addr(k + 1), "read address");
            if (k % ROW_COUNT == ROW_COUNT - 1 && k < LOCATIONS - 1) begin
                frame = (frame == FRAME_LAST) ? FRAME_RESET : frame + 4'h1;
                tag_round();
            end
            if (k == 219) check(section_one_empty && !store_overflow_flag, "not freed");
        end
        check(empties === 3'h7 && store_overflow_flag === 1'b0, "flags after drain");
        pulse(1);
        wait_access(0);
        check(!started, "read of drained store taken");
        report_and_stop();
    end
endmodule : cbs_core_buffer_sequencer_bench
